//--- rtl/hisc_pkg.sv
// Constants and types shared by the HALT / IDLE standby controller.
// Assumes a single clock MCLK and a synchronous active-high reset.
// Overview of operation
// - Reset pin or watchdog reset in HALT runs the ordinary reset sequence.
// - HALT freezes CPU state and RAM by stopping the CPU clock and holding RAM.
// - Ports keep their output state and configuration throughout HALT.
// - Real-time counter runs in standby if subclock present or main divider selected.
// - A D/A conversion started before HALT completes, then its output is held; real-time mode keeps the converter clocked.
// - IDLE entered when select bit is 0 and stop bit written as 1.
// - IDLE keeps oscillator on, gates CPU and peripherals except externally clocked serial, running RTC and busy D/A.
// - Internal RAM contents are held throughout IDLE.
// - Leaving IDLE returns to normal at once, no stabilisation wait.
// - IDLE ends on non-maskable, unmasked external, unmasked running peripheral, or reset.
// - Any non-maskable or unmasked maskable request ends standby regardless of priority.
// - In a routine, a lower-priority request only wakes; it stays pending.
// - In a routine, a higher-priority or non-maskable request wakes and is acknowledged.
// - After a non-maskable wake, execution always branches to its handler.
// - Maskable wake with interrupts disabled resumes at the next instruction.
// - HALT entered by halt instruction; CPU and ROM controller clocks are gated, RTC and D/A as above.
// - HALT ends on interrupts, reset pin or watchdog, with IDLE priority handling.
package hisc_pkg;

    localparam int unsigned N_EXT_IRQ   = 7;
    localparam int unsigned N_CSI       = 5;
    localparam int unsigned PRIO_W      = 3;
    localparam int unsigned N_CLK_EN    = 12;

    // Clock-enable bit positions
    localparam int unsigned CE_CPU      = 0;
    localparam int unsigned CE_ROMC     = 1;
    localparam int unsigned CE_DMA      = 2;
    localparam int unsigned CE_INTC     = 3;
    localparam int unsigned CE_TMR_WIDE = 4;
    localparam int unsigned CE_TMR_NARR = 5;
    localparam int unsigned CE_WDT      = 6;
    localparam int unsigned CE_UART     = 7;
    localparam int unsigned CE_I2C      = 8;
    localparam int unsigned CE_RTC      = 9;
    localparam int unsigned CE_ADC      = 10;
    localparam int unsigned CE_DAC      = 11;

    // Reset values
    localparam logic                RST_SELECT_BIT = 1'b0;
    localparam logic [N_CLK_EN-1:0] RST_CLK_EN     = 12'hfff;
    localparam logic [N_CSI-1:0]    RST_CSI_EN     = 5'h1f;

    typedef enum logic [1:0] {
        HISC_NORMAL = 2'b00,
        HISC_HALT   = 2'b01,
        HISC_IDLE   = 2'b11
    } hisc_mode_t;

endpackage : hisc_pkg

//--- rtl/hisc_gate.sv
// Registered enable bank: one flip-flop per gated clock enable.
// Assumes the enables drive glitch-free clock gates outside this block.
`timescale 1ns/100ps
`default_nettype none
module hisc_gate #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Enables
    input  wire logic [W-1:0] nxt_en,
    output logic      [W-1:0] en
);

    logic [W-1:0] en_ff;

    // Refuse an empty bank at elaboration
    if (W < 1) begin : g_bad_w
        $error("hisc_gate: W must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            en_ff <= RST_VAL;
        end else begin
            en_ff <= nxt_en;
        end
    end

    assign en = en_ff;

endmodule : hisc_gate
`default_nettype wire

//--- rtl/hisc_ctrl.sv
// HALT / IDLE standby controller: mode state, clock gating, wake decision.
// Assumes the CPU core gives one-cycle strobes for the halt instruction and
// for stores to the two power-save registers, and that the interrupt
// controller supplies priorities (lower number means higher priority).
`timescale 1ns/100ps
`default_nettype none
module hisc_ctrl (
    // Clock and reset
    input  wire logic                              MCLK,
    input  wire logic                              SRST,
    // Reset sources
    input  wire logic                              RESET_PIN,
    input  wire logic                              WDT_RESET,
    // CPU core strobes
    input  wire logic                              HALT_EXEC,
    input  wire logic                              MODE_REG_WR,
    input  wire logic                              MODE_REG_WDATA,
    input  wire logic                              CTRL_REG_WR,
    input  wire logic                              CTRL_REG_WDATA,
    // Interrupt requests and status
    input  wire logic                              NMI_REQ,
    input  wire logic [hisc_pkg::N_EXT_IRQ-1:0]    EXTERNAL_IRQ_PINS,
    input  wire logic [hisc_pkg::N_EXT_IRQ-1:0]    EXT_IRQ_MASK,
    input  wire logic                              PERIPH_IRQ,
    input  wire logic                              PERIPH_IRQ_MASK,
    input  wire logic [hisc_pkg::PRIO_W-1:0]       REQ_PRIO,
    input  wire logic [hisc_pkg::PRIO_W-1:0]       SERVICE_PRIO,
    input  wire logic                              IN_SERVICE,
    input  wire logic                              IRQ_ENABLED_STATE,
    // Peripheral clock configuration
    input  wire logic                              SUBCLK_PRESENT,
    input  wire logic                              RTC_MAIN_DIV_SEL,
    input  wire logic [hisc_pkg::N_CSI-1:0]        CSI_EXT_CLK_SEL,
    input  wire logic                              DAC_BUSY,
    input  wire logic                              DAC_REALTIME,
    // Clock gating
    output logic                                   MAIN_OSC_EN,
    output logic      [hisc_pkg::N_CLK_EN-1:0]     CLK_EN,
    output logic      [hisc_pkg::N_CSI-1:0]        CSI_CLK_EN,
    // State holding
    output logic                                   PORT_HOLD,
    output logic                                   RAM_HOLD,
    output logic      [1:0]                        MODE,
    // Wake and reset results
    output logic                                   SYS_RESET_REQ,
    output logic                                   WAKE,
    output logic                                   IRQ_ACK,
    output logic                                   NMI_BRANCH,
    output logic                                   RESUME_NEXT,
    output logic                                   KEEP_PENDING
);
    import hisc_pkg::*;

    hisc_mode_t              mode_ff;
    hisc_mode_t              nxt_mode;
    logic                    select_ff;
    logic                    nxt_select;
    logic                    hold_ff;
    logic                    nxt_hold;
    logic                    rst_ff;
    logic                    nxt_rst;
    logic [4:0]              wake_ff;
    logic [4:0]              nxt_wake;
    logic [N_CLK_EN-1:0]     nxt_clk_en;
    logic [N_CSI-1:0]        nxt_csi_en;
    logic                    maskable_req;
    logic                    wake_req;
    logic                    reset_req;
    logic                    take_irq;

    assign maskable_req = (|(EXTERNAL_IRQ_PINS & ~EXT_IRQ_MASK))
                        | (PERIPH_IRQ & ~PERIPH_IRQ_MASK);
    assign wake_req     = NMI_REQ | maskable_req;
    assign reset_req    = RESET_PIN | (WDT_RESET & (mode_ff != HISC_IDLE));
    // Maskable request taken only when enabled and, inside a routine, of higher priority
    assign take_irq     = IRQ_ENABLED_STATE & (~IN_SERVICE | (REQ_PRIO < SERVICE_PRIO));

    // Mode state and wake decision
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_select = select_ff;
        nxt_rst    = 1'b0;
        nxt_wake   = 5'h00;
        if (MODE_REG_WR) begin
            nxt_select = MODE_REG_WDATA;
        end
        if (reset_req) begin
            nxt_mode   = HISC_NORMAL;
            nxt_select = RST_SELECT_BIT;
            nxt_rst    = 1'b1;
        end else begin
            unique case (mode_ff)
                HISC_NORMAL: begin
                    if (HALT_EXEC) begin
                        nxt_mode = HISC_HALT;
                    end else if (CTRL_REG_WR && CTRL_REG_WDATA && !select_ff) begin
                        nxt_mode = HISC_IDLE;
                    end
                end
                HISC_HALT, HISC_IDLE: begin
                    if (wake_req) begin
                        // Straight back to normal: the oscillator never stopped
                        nxt_mode = HISC_NORMAL;
                        // Bits from 0: wake, keep pending, resume next, nmi branch, ack
                        if (NMI_REQ) begin
                            nxt_wake = 5'h19;
                        end else if (take_irq) begin
                            nxt_wake = 5'h11;
                        end else if (!IRQ_ENABLED_STATE) begin
                            nxt_wake = 5'h07;
                        end else begin
                            nxt_wake = 5'h07;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            mode_ff   <= HISC_NORMAL;
            select_ff <= RST_SELECT_BIT;
            rst_ff    <= 1'b0;
            wake_ff   <= 5'h00;
        end else begin
            mode_ff   <= nxt_mode;
            select_ff <= nxt_select;
            rst_ff    <= nxt_rst;
            wake_ff   <= nxt_wake;
        end
    end

    // Clock enables follow the next mode so gating lines up with the state change
    always_comb begin
        nxt_hold   = (nxt_mode != HISC_NORMAL);
        nxt_clk_en = RST_CLK_EN;
        nxt_csi_en = RST_CSI_EN;
        unique case (nxt_mode)
            HISC_NORMAL: begin
                nxt_clk_en = RST_CLK_EN;
            end
            HISC_HALT: begin
                nxt_clk_en[CE_CPU]  = 1'b0;
                nxt_clk_en[CE_ROMC] = 1'b0;
                nxt_clk_en[CE_RTC]  = SUBCLK_PRESENT | RTC_MAIN_DIV_SEL;
                // Finish a running conversion, then hold the output; real-time mode keeps the converter clocked
                nxt_clk_en[CE_DAC]  = DAC_BUSY | DAC_REALTIME;
            end
            HISC_IDLE: begin
                nxt_clk_en          = '0;
                nxt_clk_en[CE_RTC]  = SUBCLK_PRESENT | RTC_MAIN_DIV_SEL;
                nxt_clk_en[CE_ADC]  = 1'b0;
                nxt_clk_en[CE_DAC]  = DAC_BUSY;
                nxt_csi_en          = CSI_EXT_CLK_SEL;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    hisc_gate #(
        .W       (N_CLK_EN + N_CSI),
        .RST_VAL ({RST_CSI_EN, RST_CLK_EN})
    ) u_gate (
        .clk     (MCLK),
        .srst    (SRST),
        .nxt_en  ({nxt_csi_en, nxt_clk_en}),
        .en      ({CSI_CLK_EN, CLK_EN})
    );

    // Oscillator runs in both modes; software stop mode is not handled here
    assign MAIN_OSC_EN   = 1'b1;
    assign PORT_HOLD     = hold_ff;
    assign RAM_HOLD      = hold_ff;
    assign MODE          = mode_ff;
    assign SYS_RESET_REQ = rst_ff;
    assign WAKE          = wake_ff[0];
    assign KEEP_PENDING  = wake_ff[1];
    assign RESUME_NEXT   = wake_ff[2];
    assign NMI_BRANCH    = wake_ff[3];
    assign IRQ_ACK       = wake_ff[4];

endmodule : hisc_ctrl
`default_nettype wire

//--- verification/hisc_cpu_model.sv
// Behavioural CPU core that issues the halt strobe and the standby stores.
// Assumes one clock; commands are dropped while the no-op slots run.
`timescale 1ns/100ps
`default_nettype none
module hisc_cpu_model (
    // Clock, reset and commands
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic go_halt,
    input  wire logic go_idle,
    // Core strobes
    output logic      halt_exec,
    output logic      mode_wr,
    output logic      mode_wdata,
    output logic      ctrl_wr,
    output logic      ctrl_wdata
);
    logic [2:0] nop_cnt;
    logic       ready;
    assign ready = !srst && nop_cnt == 3'h0;
    // Data flips when unqualified so a stale value never passes
    assign mode_wdata = !mode_wr;
    assign ctrl_wdata = ctrl_wr;
    always_ff @(posedge mclk) begin
        halt_exec <= go_halt && ready;
        mode_wr   <= go_idle && ready;
        ctrl_wr   <= mode_wr && !srst;
        nop_cnt   <= srst ? 3'h0 : (ctrl_wr || halt_exec) ? 3'h5
                   : nop_cnt - {2'h0, nop_cnt != 3'h0};
    end
endmodule : hisc_cpu_model
`default_nettype wire

//--- verification/hisc_checker.sv
// Checker bound to hisc_ctrl, seeing only its ports.
// Assumes the single clock MCLK and synchronous reset SRST.
`timescale 1ns/100ps
`default_nettype none
module hisc_checker (
    // Clock, reset and causes
    input wire logic                          MCLK, SRST, RESET_PIN, WDT_RESET,
    input wire logic                          HALT_EXEC, NMI_REQ, DAC_BUSY,
    input wire logic [hisc_pkg::N_CSI-1:0]    CSI_EXT_CLK_SEL,
    // Results
    input wire logic                          MAIN_OSC_EN, PORT_HOLD, RAM_HOLD, WAKE,
    input wire logic                          IRQ_ACK, NMI_BRANCH, RESUME_NEXT,
    input wire logic                          KEEP_PENDING, SYS_RESET_REQ,
    input wire logic [1:0]                    MODE,
    input wire logic [hisc_pkg::N_CLK_EN-1:0] CLK_EN,
    input wire logic [hisc_pkg::N_CSI-1:0]    CSI_CLK_EN
);
    import hisc_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);
    logic quiet;
    assign quiet = !RESET_PIN && !WDT_RESET;
    property p_halt; HALT_EXEC && MODE == 2'b00 && quiet |=> MODE == 2'b01
        && CLK_EN[CE_ROMC:CE_CPU] == 2'b00 && &CLK_EN[CE_I2C:CE_DMA]; endproperty
    a_halt: assert property (p_halt) else $error("halt entry wrong");
    property p_hold; MODE != 2'b00 |-> PORT_HOLD && RAM_HOLD; endproperty
    a_hold: assert property (p_hold) else $error("hold missing");
    property p_osc; MAIN_OSC_EN; endproperty
    a_osc: assert property (p_osc) else $error("oscillator off");
    property p_nmi; MODE != 2'b00 && NMI_REQ && quiet |=> MODE == 2'b00 && WAKE
        && IRQ_ACK && NMI_BRANCH; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi wake wrong");
    property p_reset; RESET_PIN |=> SYS_RESET_REQ && MODE == 2'b00 && !WAKE; endproperty
    a_reset: assert property (p_reset) else $error("reset wrong");
    property p_idle; MODE == 2'b11 |-> CLK_EN[CE_I2C:CE_CPU] == '0 && !CLK_EN[CE_ADC]
        && CSI_CLK_EN == $past(CSI_EXT_CLK_SEL); endproperty
    a_idle: assert property (p_idle) else $error("idle gating wrong");
    property p_dac; MODE == 2'b11 |-> CLK_EN[CE_DAC] == $past(DAC_BUSY); endproperty
    a_dac: assert property (p_dac) else $error("converter enable wrong");
    property p_wake; WAKE |-> MODE == 2'b00 && CLK_EN[CE_CPU] ##1 !WAKE; endproperty
    a_wake: assert property (p_wake) else $error("wake not immediate");
    property p_keep; KEEP_PENDING |-> WAKE && RESUME_NEXT && !IRQ_ACK; endproperty
    a_keep: assert property (p_keep) else $error("pending wake acked");
    c_halt: cover property (HALT_EXEC ##1 MODE == 2'b01);
    c_pend: cover property (KEEP_PENDING);
    c_rst: cover property (SYS_RESET_REQ && MODE == 2'b00);
endmodule : hisc_checker
`default_nettype wire

//--- verification/hisc_ctrl_test.sv
// Self-checking bench for hisc_ctrl with a behavioural CPU core.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module hisc_ctrl_test;
    import hisc_pkg::*;
    logic MCLK = 1'b0, SRST = 1'b1, RESET_PIN = 1'b0, WDT_RESET = 1'b0, NMI_REQ = 1'b0;
    logic PERIPH_IRQ = 1'b0, PERIPH_IRQ_MASK = 1'b1, IN_SERVICE = 1'b0, IRQ_ENABLED_STATE = 1'b1;
    logic SUBCLK_PRESENT = 1'b0, RTC_MAIN_DIV_SEL = 1'b0, DAC_BUSY = 1'b0, DAC_REALTIME = 1'b0;
    logic go_halt = 1'b0, go_idle = 1'b0;
    logic [N_EXT_IRQ-1:0] EXTERNAL_IRQ_PINS = 7'h00, EXT_IRQ_MASK = 7'h00;
    logic [PRIO_W-1:0] REQ_PRIO = 3'h0, SERVICE_PRIO = 3'h0;
    logic [N_CSI-1:0] CSI_EXT_CLK_SEL = 5'h00, CSI_CLK_EN;
    logic [N_CLK_EN-1:0] CLK_EN;
    logic [1:0] MODE;
    logic HALT_EXEC, MODE_REG_WR, MODE_REG_WDATA, CTRL_REG_WR, CTRL_REG_WDATA, MAIN_OSC_EN;
    logic PORT_HOLD, RAM_HOLD, SYS_RESET_REQ, WAKE, IRQ_ACK, NMI_BRANCH, RESUME_NEXT, KEEP_PENDING;
    int errors = 0, n_compared = 0;
    hisc_cpu_model CPU (.mclk(MCLK), .srst(SRST), .go_halt(go_halt), .go_idle(go_idle),
        .halt_exec(HALT_EXEC), .mode_wr(MODE_REG_WR), .mode_wdata(MODE_REG_WDATA),
        .ctrl_wr(CTRL_REG_WR), .ctrl_wdata(CTRL_REG_WDATA));
    hisc_ctrl DUT (.*);
    always #2.5 MCLK = ~MCLK;
    task automatic chk(input string what, input logic [19:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic enter(input logic halt, input logic [1:0] exp);
        repeat (6) @(posedge MCLK);
        go_halt <= halt;
        go_idle <= !halt;
        @(posedge MCLK);
        go_halt <= 1'b0;
        go_idle <= 1'b0;
        for (int i = 0; i < 8 && MODE !== exp; i++) begin
            @(posedge MCLK);
            #1;
        end
        chk("mode", 20'(MODE), 20'(exp));
    endtask : enter
    // Request stands one cycle only, so a late wake shows up as a miss
    task automatic wake(input logic nmi, input logic [2:0] prio, input logic [6:0] exp);
        @(posedge MCLK);
        NMI_REQ <= nmi;
        EXTERNAL_IRQ_PINS <= {!nmi, 6'h00};
        REQ_PRIO <= prio;
        @(posedge MCLK);
        NMI_REQ <= 1'b0;
        EXTERNAL_IRQ_PINS <= 7'h00;
        #1;
        chk("wake", 20'({MODE, WAKE, IRQ_ACK, NMI_BRANCH, RESUME_NEXT, KEEP_PENDING}), 20'(exp));
    endtask : wake
    task automatic t_halt_nmi;
        enter(1'b1, 2'b01);
        chk("halt gating", 20'(CLK_EN), 20'h005fc);
        chk("halt holds", 20'({PORT_HOLD, RAM_HOLD, MAIN_OSC_EN}), 20'h7);
        wake(1'b1, 3'h0, 7'h1c);
        chk("normal gating", 20'(CLK_EN), 20'h00fff);
    endtask : t_halt_nmi
    task automatic t_idle;
        @(posedge MCLK);
        SUBCLK_PRESENT <= 1'b1;
        DAC_BUSY <= 1'b1;
        CSI_EXT_CLK_SEL <= 5'h0a;
        IN_SERVICE <= 1'b1;
        SERVICE_PRIO <= 3'h2;
        EXT_IRQ_MASK <= 7'h40;
        enter(1'b0, 2'b11);
        chk("idle gating", 20'({CSI_CLK_EN, CLK_EN}), 20'h0aa00);
        chk("idle holds", 20'({PORT_HOLD, RAM_HOLD, MAIN_OSC_EN}), 20'h7);
        @(posedge MCLK);
        DAC_BUSY <= 1'b0;
        wake(1'b0, 3'h5, 7'h60);
        @(posedge MCLK);
        EXT_IRQ_MASK <= 7'h00;
        wake(1'b0, 3'h5, 7'h13);
        enter(1'b0, 2'b11);
        wake(1'b0, 3'h1, 7'h18);
        @(posedge MCLK);
        IN_SERVICE <= 1'b0;
        IRQ_ENABLED_STATE <= 1'b0;
        enter(1'b0, 2'b11);
        wake(1'b0, 3'h1, 7'h13);
    endtask : t_idle
    task automatic t_halt_reset;
        enter(1'b1, 2'b01);
        @(posedge MCLK);
        RESET_PIN <= 1'b1;
        @(posedge MCLK);
        RESET_PIN <= 1'b0;
        #1;
        chk("reset", 20'({SYS_RESET_REQ, MODE, CLK_EN}), 20'h04fff);
    endtask : t_halt_reset
    task automatic t_halt_wdt;
        @(posedge MCLK);
        SUBCLK_PRESENT <= 1'b0;
        RTC_MAIN_DIV_SEL <= 1'b1;
        DAC_REALTIME <= 1'b1;
        enter(1'b1, 2'b01);
        chk("halt divider gating", 20'(CLK_EN), 20'h00ffc);
        @(posedge MCLK);
        WDT_RESET <= 1'b1;
        @(posedge MCLK);
        WDT_RESET <= 1'b0;
        #1;
        chk("watchdog reset", 20'({SYS_RESET_REQ, MODE, CLK_EN}), 20'h04fff);
    endtask : t_halt_wdt
    initial begin
        repeat (16) @(posedge MCLK);
        SRST <= 1'b0;
        t_halt_nmi();
        t_idle();
        t_halt_reset();
        t_halt_wdt();
        stop_test();
    end
    // Whole run needs about ninety cycles
    initial begin
        repeat (2000) @(posedge MCLK);
        errors++;
        stop_test();
    end
endmodule : hisc_ctrl_test
bind hisc_ctrl hisc_checker CHK (.*);
`default_nettype wire
